// ===== inc/ubg_pkg.sv
// Shared constants for the baud rate generator: register map, reset values, field layout.
// Assumes a 32-bit AXI4-Lite register bus and a single main clock.
package ubg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] CTRL_INDEX = 32'hfffffa20;
  localparam logic [31:0] BCS_INDEX  = 32'hfffffa21;
  localparam logic [31:0] DIV_INDEX  = 32'hfffffa22;
  localparam logic [31:0] STAT_INDEX = 32'hfffffa23;
  localparam logic [31:0] CTRL_ADDR  = {CTRL_INDEX[29:0], 2'b00};
  localparam logic [31:0] BCS_ADDR   = {BCS_INDEX[29:0], 2'b00};
  localparam logic [31:0] DIV_ADDR   = {DIV_INDEX[29:0], 2'b00};
  localparam logic [31:0] STAT_ADDR  = {STAT_INDEX[29:0], 2'b00};

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BCS_RESET  = 8'h00;
  localparam logic [7:0] DIV_RESET  = 8'hff;

  // Divisor lower limit and source codes
  localparam logic [7:0] DIV_MIN      = 8'h04;
  localparam logic [3:0] CODE_INT_MAX = 4'ha;
  localparam logic [3:0] CODE_EXT     = 4'hb;

  // Control register bit positions
  localparam int PWR_BIT = 0;
  localparam int TXE_BIT = 1;
  localparam int RXE_BIT = 2;

  // Prescaler width: divide by up to 1,024
  localparam int PRESC_W = 10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_BCS,
    SEL_DIV,
    SEL_STAT,
    SEL_NONE
  } ubg_sel_e;

endpackage : ubg_pkg

// ===== src/ubg_div_counter.sv
// One 8-bit divisor counter: base ticks in, serial tick and halved bit clock out.
// Assumes base ticks are one-cycle pulses on the main clock.
`timescale 1ns/1ps
module ubg_div_counter
  import ubg_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_run,
  input  wire logic       i_base_tick,
  input  wire logic [7:0] i_divisor,
  output logic            o_serial_tick,
  output logic            o_bit_clk,
  output logic            o_bit_tick
);

  logic [7:0] cnt_reg;
  logic       last;
  logic       wrap;

  // Compare with >= so a divisor shrunk mid-count still wraps
  assign last = (cnt_reg >= (i_divisor - 8'h01));
  assign wrap = i_run & i_base_tick & last;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= 8'h00;
    end else if (!i_run) begin
      cnt_reg <= 8'h00;
    end else if (i_base_tick) begin
      cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_serial_tick <= 1'b0;
      o_bit_clk     <= 1'b0;
      o_bit_tick    <= 1'b0;
    end else begin
      o_serial_tick <= wrap;
      o_bit_clk     <= i_run & (o_bit_clk ^ wrap);
      o_bit_tick    <= wrap & o_bit_clk;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_SERIAL_CAUSE: assert property (
    o_serial_tick |-> $past(i_run && i_base_tick && cnt_reg >= i_divisor - 8'h01))
    else $error("Serial tick without a divisor wrap");

  AST_BIT_HALF: assert property (
    o_serial_tick && $past(i_run, 2) |-> o_bit_clk != $past(o_bit_clk))
    else $error("Bit clock did not toggle on serial tick");

  AST_BIT_TICK_PAIR: assert property (
    o_bit_tick |-> o_serial_tick && !o_bit_clk)
    else $error("Bit tick not on falling bit clock");

endmodule : ubg_div_counter

// ===== src/ubg_top.sv
// Baud rate generator for one serial channel with an AXI4-Lite register slave.
// Assumes all inputs synchronous to i_mclk; external baud clock well below i_mclk / 2.
`timescale 1ns/1ps
module ubg_top
  import ubg_pkg::*;
#(
  parameter bit IS_CHANNEL_ZERO = 1'b1
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_ext_baud_clk,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_awaddr,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  output logic             o_axi_bvalid,
  input  wire logic        i_axi_bready,
  output logic [1:0]       o_axi_bresp,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  input  wire logic [31:0] i_axi_araddr,
  output logic             o_axi_rvalid,
  input  wire logic        i_axi_rready,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  output logic             o_tx_serial_tick,
  output logic             o_tx_bit_clk,
  output logic             o_tx_bit_tick,
  output logic             o_rx_serial_tick,
  output logic             o_rx_bit_clk,
  output logic             o_rx_bit_tick
);

  function automatic ubg_sel_e addr_sel(input logic [31:0] a);
    case (a)
      CTRL_ADDR: addr_sel = SEL_CTRL;
      BCS_ADDR:  addr_sel = SEL_BCS;
      DIV_ADDR:  addr_sel = SEL_DIV;
      STAT_ADDR: addr_sel = SEL_STAT;
      default:   addr_sel = SEL_NONE;
    endcase
  endfunction : addr_sel

  // Registers
  logic [7:0] ctrl_reg;
  logic [7:0] bcs_reg;
  logic [7:0] div_reg;
  logic       pwr;
  logic       txe;
  logic       rxe;
  logic [3:0] code;

  assign pwr  = ctrl_reg[PWR_BIT];
  assign txe  = ctrl_reg[TXE_BIT];
  assign rxe  = ctrl_reg[RXE_BIT];
  assign code = bcs_reg[3:0];

  // Write channel
  logic        aw_hold_reg;
  logic [31:0] aw_addr_reg;
  logic        w_hold_reg;
  logic [7:0]  w_data_reg;
  logic        w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        aw_take;
  logic        w_take;
  logic        aw_have;
  logic        w_have;
  logic        wr_fire;
  logic [31:0] wr_addr;
  logic [7:0]  wr_data;
  logic        wr_strb;
  ubg_sel_e    wr_sel;
  logic [1:0]  wr_resp;

  assign o_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign o_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign aw_take = i_axi_awvalid && o_axi_awready;
  assign w_take  = i_axi_wvalid && o_axi_wready;
  assign aw_have = aw_hold_reg || aw_take;
  assign w_have  = w_hold_reg || w_take;
  assign wr_fire = aw_have && w_have && !bvalid_reg;
  assign wr_addr = aw_hold_reg ? aw_addr_reg : i_axi_awaddr;
  assign wr_data = w_hold_reg ? w_data_reg : i_axi_wdata[7:0];
  assign wr_strb = w_hold_reg ? w_strb_reg : i_axi_wstrb[0];
  assign wr_sel  = addr_sel(wr_addr);

  always_comb begin
    case (wr_sel)
      SEL_NONE: wr_resp = RESP_DECERR;
      SEL_DIV:  wr_resp = (wr_strb && wr_data < DIV_MIN) ? RESP_SLVERR : RESP_OKAY;
      default:  wr_resp = RESP_OKAY;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end else if (aw_take) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= i_axi_awaddr;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end else if (w_take) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= i_axi_wdata[7:0];
      w_strb_reg <= i_axi_wstrb[0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_resp;
    end else if (i_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_axi_bvalid = bvalid_reg;
  assign o_axi_bresp  = bresp_reg;

  // Register updates; sequencing of power and enables is left to software
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && wr_strb && wr_sel == SEL_CTRL) begin
      ctrl_reg <= {5'h00, wr_data[2:0]};
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      bcs_reg <= BCS_RESET;
    end else if (wr_fire && wr_strb && wr_sel == SEL_BCS) begin
      bcs_reg <= {4'h0, wr_data[3:0]};
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      div_reg <= DIV_RESET;
    end else if (wr_fire && wr_strb && wr_sel == SEL_DIV && wr_data >= DIV_MIN) begin
      div_reg <= wr_data;
    end
  end

  // Base clock selection
  logic [PRESC_W-1:0] presc_reg;
  logic               ext_q_reg;
  logic               ext_rise;
  logic [PRESC_W-1:0] presc_mask;
  logic               base_tick;
  logic               ext_ok;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      presc_reg <= '0;
    end else if (!pwr) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= i_ext_baud_clk;
    end
  end

  assign ext_rise   = i_ext_baud_clk && !ext_q_reg;
  assign ext_ok     = IS_CHANNEL_ZERO && code == CODE_EXT;
  assign presc_mask = PRESC_W'((11'h001 << code) - 11'h001);

  always_comb begin
    if (!pwr) begin
      base_tick = 1'b0;
    end else if (code <= CODE_INT_MAX) begin
      base_tick = (presc_reg & presc_mask) == presc_mask;
    end else if (ext_ok) begin
      base_tick = ext_rise;
    end else begin
      base_tick = 1'b0;
    end
  end

  // Transmit (0) and receive (1) counters
  logic [1:0] run;
  logic [1:0] serial_tick;
  logic [1:0] bit_clk;
  logic [1:0] bit_tick;

  assign run[0] = pwr && txe;
  assign run[1] = pwr && rxe;

  for (genvar g = 0; g < 2; g++) begin : g_path
    ubg_div_counter u_cnt (
      .i_mclk        (i_mclk),
      .i_reset       (i_reset),
      .i_run         (run[g]),
      .i_base_tick   (base_tick),
      .i_divisor     (div_reg),
      .o_serial_tick (serial_tick[g]),
      .o_bit_clk     (bit_clk[g]),
      .o_bit_tick    (bit_tick[g])
    );
  end

  assign o_tx_serial_tick = serial_tick[0];
  assign o_tx_bit_clk     = bit_clk[0];
  assign o_tx_bit_tick    = bit_tick[0];
  assign o_rx_serial_tick = serial_tick[1];
  assign o_rx_bit_clk     = bit_clk[1];
  assign o_rx_bit_tick    = bit_tick[1];

  // Read channel
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [7:0]  rd_byte;
  ubg_sel_e    rd_sel;

  assign o_axi_arready = !rvalid_reg;
  assign rd_sel = addr_sel(i_axi_araddr);

  always_comb begin
    case (rd_sel)
      SEL_CTRL: rd_byte = ctrl_reg;
      SEL_BCS:  rd_byte = bcs_reg;
      SEL_DIV:  rd_byte = div_reg;
      SEL_STAT: rd_byte = {4'h0, ext_ok, bit_clk[1], bit_clk[0], pwr};
      default:  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (i_axi_arvalid && o_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (i_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_axi_rvalid = rvalid_reg;
  assign o_axi_rdata  = rdata_reg;
  assign o_axi_rresp  = rresp_reg;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_wr_pair;
    aw_have && w_have && !bvalid_reg;
  endsequence

  sequence s_div_ok;
    wr_fire && wr_strb && wr_sel == SEL_DIV && wr_data >= DIV_MIN;
  endsequence

  sequence s_div_bad;
    wr_fire && wr_strb && wr_sel == SEL_DIV && wr_data < DIV_MIN;
  endsequence

  AST_BCS_UPPER_ZERO: assert property (bcs_reg[7:4] == 4'h0)
    else $error("Upper select bits not zero");

  AST_DIV_LEGAL: assert property (div_reg >= DIV_MIN)
    else $error("Divisor below four");

  AST_DIV_WRITE: assert property (
    s_div_ok |=> div_reg == $past(wr_data) && o_axi_bvalid && o_axi_bresp == RESP_OKAY)
    else $error("Divisor write not stored");

  AST_DIV_REFUSE: assert property (
    s_div_bad |=> $stable(div_reg) && o_axi_bresp == RESP_SLVERR)
    else $error("Prohibited divisor not refused");

  AST_WR_RESP: assert property (s_wr_pair |=> o_axi_bvalid)
    else $error("Write response missing");

  AST_RD_RESP: assert property (
    i_axi_arvalid && o_axi_arready |=> o_axi_rvalid ##0 (o_axi_rvalid throughout !o_axi_arready))
    else $error("Read response missing");

  AST_NO_TICK_OFF: assert property (!pwr |-> !base_tick)
    else $error("Base tick while unpowered");

  AST_CODE0_FULL: assert property (pwr && code == 4'h0 |-> base_tick)
    else $error("Code zero not undivided");

  AST_CODE2_GAP: assert property (
    base_tick && pwr && code == 4'h2 ##1 pwr && code == 4'h2 |-> !base_tick ##1 !base_tick)
    else $error("Divide by four tick spacing wrong");

  AST_EXT_GATED: assert property (
    pwr && code == CODE_EXT |-> base_tick == (IS_CHANNEL_ZERO && ext_rise))
    else $error("External clock selection wrong");

  AST_BAD_CODE: assert property (code > CODE_EXT |-> !base_tick)
    else $error("Tick from undefined source code");

  AST_TX_IDLE: assert property (!run[0] ##1 !run[0] |-> !o_tx_serial_tick)
    else $error("Transmit counter ran while disabled");

endmodule : ubg_top

// ===== dv/ubg_top_tb_top.sv
// Self-checking bench for the baud rate generator: register bus and tick periods.
// Assumes the package register map; every bus answer is awaited in a bounded loop.
`timescale 1ns/1ps
module ubg_top_tb_top
  import ubg_pkg::*;
;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        ext_clk = 1'b0;
  logic        ext_en = 1'b0;
  logic [1:0]  ext_cnt = 2'd0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        tx_ser, tx_clk, tx_bit, rx_ser, rx_clk, rx_bit;
  int          err_count = 0;
  int          checks_done = 0;
  localparam real MCLK_HZ = 100.0e6;

  always #5 mclk = ~mclk;

  // External base clock, period six main cycles
  always @(posedge mclk) begin
    if (ext_en) begin
      ext_cnt <= (ext_cnt == 2'd2) ? 2'd0 : ext_cnt + 2'd1;
      if (ext_cnt == 2'd2) ext_clk <= ~ext_clk;
    end
  end

  ubg_top #(.IS_CHANNEL_ZERO(1'b1)) dut (
    .i_mclk(mclk), .i_reset(reset), .i_ext_baud_clk(ext_clk),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
    .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .o_tx_serial_tick(tx_ser), .o_tx_bit_clk(tx_clk), .o_tx_bit_tick(tx_bit),
    .o_rx_serial_tick(rx_ser), .o_rx_bit_clk(rx_clk), .o_rx_bit_tick(rx_bit)
  );

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic hang(input string what);
    check(32'h1, 32'h0, what);
    report_and_stop();
  endtask : hang

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done, a_r, w_r, b_r;
    int   n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'h1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge mclk);
      a_r = awready;
      w_r = wready;
      @(posedge mclk);
      if (a_r === 1'b1 && !aw_done) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_r === 1'b1 && !w_done) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
      if (++n > 100) hang("write not taken");
    end
    b_r = 1'b0;
    while (b_r !== 1'b1) begin
      @(negedge mclk);
      b_r = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (++n > 200) hang("write answer missing");
    end
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_r, r_r;
    int   n;
    ar_r = 1'b0;
    r_r = 1'b0;
    n = 0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (ar_r !== 1'b1) begin
      @(negedge mclk);
      ar_r = arready;
      @(posedge mclk);
      if (++n > 100) hang("read not taken");
    end
    arvalid <= 1'b0;
    while (r_r !== 1'b1) begin
      @(negedge mclk);
      r_r = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge mclk);
      if (++n > 200) hang("read answer missing");
    end
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr_ok(input logic [31:0] a, input logic [7:0] v);
    logic [1:0] r;
    axi_write(a, {24'h0, v}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask : wr_ok

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] v, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, {24'h0, v}, what);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
  endtask : rd_chk

  function automatic logic pick(input int sel);
    case (sel)
      0: return tx_ser;
      1: return tx_bit;
      2: return rx_ser;
      default: return rx_bit;
    endcase
  endfunction : pick

  // Cycles between two consecutive pulses of the chosen output
  task automatic gap(input int sel, output int g);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      if (++n > 40000) hang("no tick");
    end while (pick(sel) !== 1'b1);
    g = 0;
    do begin
      @(negedge mclk);
      g++;
      if (g > 40000) hang("no second tick");
    end while (pick(sel) !== 1'b1);
  endtask : gap

  task automatic setup(input logic [7:0] code, input logic [7:0] k, input logic [7:0] ctrl);
    wr_ok(CTRL_ADDR, 8'h00);
    wr_ok(BCS_ADDR, code);
    wr_ok(DIV_ADDR, k);
    wr_ok(CTRL_ADDR, ctrl);
  endtask : setup

  task automatic t_reset_values();
    rd_chk(BCS_ADDR, 8'h00, "select after reset");
    rd_chk(DIV_ADDR, 8'hff, "divisor after reset");
  endtask : t_reset_values

  // Upper select bits set, but the code itself stays a defined one
  task automatic t_fields();
    logic [1:0]  r;
    logic [31:0] d;
    wr_ok(BCS_ADDR, 8'hfa);
    rd_chk(BCS_ADDR, 8'h0a, "select upper bits");
    wr_ok(DIV_ADDR, 8'h04);
    rd_chk(DIV_ADDR, 8'h04, "divisor minimum");
    axi_write(DIV_ADDR, 32'h3, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "divisor 3 refused");
    rd_chk(DIV_ADDR, 8'h04, "divisor kept");
    axi_read(32'h10, d, r);
    check({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped read");
    wr_ok(BCS_ADDR, 8'h00);
  endtask : t_fields

  task automatic t_codes();
    int g;
    for (int m = 0; m <= 10; m++) begin
      setup(8'(m), 8'h05, 8'h07);
      gap(0, g);
      check(32'(g), 32'(5 << m), "tx serial period");
    end
    setup(8'h00, 8'hff, 8'h07);
    gap(1, g);
    check(32'(g), 32'd510, "tx bit period");
    gap(2, g);
    check(32'(g), 32'd255, "rx serial period");
    gap(3, g);
    check(32'(g), 32'd510, "rx bit period");
  endtask : t_codes

  task automatic t_power_off();
    int cnt;
    setup(8'h00, 8'h04, 8'h06);
    cnt = 0;
    repeat (300) begin
      @(negedge mclk);
      if (tx_ser !== 1'b0 || rx_ser !== 1'b0 || tx_clk !== 1'b0 || rx_clk !== 1'b0 ||
          tx_bit !== 1'b0 || rx_bit !== 1'b0) cnt++;
    end
    check(32'(cnt), 32'd0, "activity without power");
  endtask : t_power_off

  task automatic t_external();
    int g;
    ext_en <= 1'b1;
    setup(8'h0b, 8'h04, 8'h03);
    gap(0, g);
    check(32'(g), 32'd24, "external serial period");
    gap(1, g);
    check(32'(g), 32'd48, "external bit period");
    ext_en <= 1'b0;
    wr_ok(CTRL_ADDR, 8'h00);
  endtask : t_external

  // Software setting search for a target rate, then bit period and rate error
  task automatic t_rate(input int rate, input int exp_m, input int exp_k);
    real kr;
    real err;
    int  m;
    int  k;
    int  g;
    kr = MCLK_HZ / (2.0 * rate);
    m = 0;
    while (kr >= 256.0) begin
      kr = kr / 2.0;
      m++;
    end
    k = $rtoi(kr + 0.5);
    if (k == 256) begin
      k = 128;
      m++;
    end
    check(32'(m), 32'(exp_m), "rate search code");
    check(32'(k), 32'(exp_k), "rate search divisor");
    setup(8'(m), 8'(k), 8'h03);
    gap(1, g);
    check(32'(g), 32'(exp_k << (exp_m + 1)), "searched bit period");
    err = (MCLK_HZ / (real'(g) * rate) - 1.0) * 100.0;
    check(32'(err < 2.32 && err > -2.43), 32'd1, "rate error in tolerance");
    wr_ok(CTRL_ADDR, 8'h00);
  endtask : t_rate

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_reset_values();
    t_fields();
    t_codes();
    t_power_off();
    t_external();
    t_rate(153600, 1, 163);
    t_rate(195500, 1, 128);
    report_and_stop();
  end
endmodule : ubg_top_tb_top
